// ===== rtl/dag_regs.vh
/*
  Constants for the data address generator: instruction fields, operation
  codes, register bus offsets and reset values.
  Assumes inclusion by bare name from the single design file.
*/
// Notes on behaviour
// - Direct address is nine-bit page above seven-bit instruction offset.
// - Page register written only by page loads or status-zero load.
// - Reset leaves page register alone; software must load it first.
// - Bits 15..8 are opcode; bit 7 low selects direct, bits 6..0 offset.
// - Direct mode for all but call, branch, immediate, no-operand opcodes.
// - Eight 16-bit auxiliary registers chosen by a 3-bit pointer.
// - Auxiliary arithmetic is unsigned 16-bit in the executing cycle.
// - Post-modification happens after old value served as address.
// - Auxiliary registers load from memory, short or long immediate.
// - Add-short, sub-short, modify-aux and indirect fields modify them.
// - Indirect mode uses full 16-bit register as address.
// - Bit-reversed indexing propagates carry from MSB toward LSB.
// - Indirect mode for all but immediate and no-operand opcodes.
// - Bit 7 high selects indirect; bits 6..0 are control fields.
// - Bit 6 low modifies by one, high by index register zero.
// - Bit 5 requests increment, bit 4 requests decrement, except 111 adds and 100 subtracts bit-reversed.
// - Pointer may be reloaded after address use, same cycle.
// - Bit 3 high copies bits 2..0 into pointer, else pointer holds.
// - Op codes 000 none,001 -1,010 +1,011 rsvd,100 -rc,101 -,110 +,111 +rc.
`ifndef DAG_REGS_VH
`define DAG_REGS_VH
`define DAG_MODE_BIT 7
`define DAG_OP_HI 6
`define DAG_OP_LO 4
`define DAG_NAR_BIT 3
`define DAG_Y_HI 2
`define DAG_OFS_HI 6
`define DAG_OP_NONE 3'h0
`define DAG_OP_DEC 3'h1
`define DAG_OP_INC 3'h2
`define DAG_OP_RSVD 3'h3
`define DAG_OP_SUBRC 3'h4
`define DAG_OP_SUB 3'h5
`define DAG_OP_ADD 3'h6
`define DAG_OP_ADDRC 3'h7
`define DAG_ONE 16'h0001
`define DAG_ADDR_CTRL 4'h0
`define DAG_ADDR_PAGE 4'h4
`define DAG_ADDR_AUX 4'h8
`define DAG_ADDR_STAT 4'hc
`define DAG_PTR_RST 3'h0
`define DAG_RESP_OKAY 2'h0
`define DAG_RESP_SLVERR 2'h2
`endif

// ===== rtl/dag_top.v
/*
  Data memory address generator: direct page+offset addressing, indirect
  auxiliary register addressing with post-modification, and pointer reload.
  Assumes the instruction decoder presents one decoded instruction per
  exec_valid pulse on aclk; software observes state over AXI4-Lite.
*/
`timescale 1ns/1ns
`include "dag_regs.vh"
module dag_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Decoded instruction
  input wire exec_valid,
  input wire [15:0] instr_word,
  input wire uses_mem_operand,
  input wire direct_allowed,
  input wire indirect_allowed,
  input wire load_page_from_memory,
  input wire load_page_immediate,
  input wire load_status_zero,
  input wire [8:0] page_value,
  input wire load_aux_from_memory,
  input wire load_aux_short,
  input wire load_aux_long,
  input wire add_aux_short,
  input wire sub_aux_short,
  input wire [15:0] aux_value,
  input wire load_pointer,
  input wire [2:0] pointer_value,
  // Data memory address bus
  output reg [15:0] data_addr,
  output reg data_addr_valid,
  output reg addr_mode_error,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  reg [15:0] aux_reg [0:7];
  reg [8:0] data_page_pointer;
  reg [2:0] aux_reg_select;
  reg [2:0] view_sel;
  reg mem_hold;

  wire indirect = instr_word[`DAG_MODE_BIT];
  wire [2:0] op = instr_word[`DAG_OP_HI:`DAG_OP_LO];
  wire index_by_zero_select = op[2];
  wire pointer_load_bit = instr_word[`DAG_NAR_BIT];
  wire [15:0] cur = aux_reg[aux_reg_select];
  wire [15:0] index_register_zero = aux_reg[0];

  // Bit-reversed add: reverse both operands, add normally, reverse back
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        rev16[k] = v[15 - k];
      end
    end
  endfunction

  reg [15:0] aux_arith_unit;
  always @* begin
    aux_arith_unit = cur;
    case (op)
      `DAG_OP_NONE: aux_arith_unit = cur;
      `DAG_OP_DEC: aux_arith_unit = cur - `DAG_ONE;
      `DAG_OP_INC: aux_arith_unit = cur + `DAG_ONE;
      `DAG_OP_RSVD: aux_arith_unit = cur;
      `DAG_OP_SUBRC: aux_arith_unit = rev16(rev16(cur) - rev16(index_register_zero));
      `DAG_OP_SUB: aux_arith_unit = cur - index_register_zero;
      `DAG_OP_ADD: aux_arith_unit = cur + index_register_zero;
      `DAG_OP_ADDRC: aux_arith_unit = rev16(rev16(cur) + rev16(index_register_zero));
      default: aux_arith_unit = cur;
    endcase
  end

  wire mem_ind = exec_valid && uses_mem_operand && indirect && indirect_allowed;
  wire mem_dir = exec_valid && uses_mem_operand && !indirect && direct_allowed;
  wire aux_imm = load_aux_short || load_aux_long || load_aux_from_memory;
  wire aux_adj = add_aux_short || sub_aux_short;

  // Address output; old register value is what goes out
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_addr <= 16'h0000;
      data_addr_valid <= 1'b0;
      addr_mode_error <= 1'b0;
    end else begin
      data_addr_valid <= mem_ind || mem_dir;
      addr_mode_error <= exec_valid && uses_mem_operand && !(mem_ind || mem_dir);
      if (mem_ind) begin
        data_addr <= cur;
      end else if (mem_dir) begin
        data_addr <= {data_page_pointer, instr_word[`DAG_OFS_HI:0]};
      end
    end
  end

  // Page register deliberately has no reset branch
  always @(posedge aclk) begin
    if (exec_valid && (load_page_from_memory || load_page_immediate || load_status_zero)) begin
      data_page_pointer <= page_value;
    end
  end

  // Auxiliary file, one generate entry per register
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_aux
      always @(posedge aclk) begin
        if (!aresetn) begin
          aux_reg[g] <= 16'h0000;
        end else if (exec_valid && aux_reg_select == g) begin
          if (aux_imm) begin
            aux_reg[g] <= aux_value;
          end else if (add_aux_short) begin
            aux_reg[g] <= cur + aux_value;
          end else if (sub_aux_short) begin
            aux_reg[g] <= cur - aux_value;
          end else if (mem_ind) begin
            aux_reg[g] <= aux_arith_unit;
          end
        end
      end
    end
  endgenerate

  // Pointer reload after the adjustment, same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      aux_reg_select <= `DAG_PTR_RST;
    end else if (exec_valid) begin
      if (load_pointer) begin
        aux_reg_select <= pointer_value;
      end else if (mem_ind && pointer_load_bit) begin
        aux_reg_select <= instr_word[`DAG_Y_HI:0];
      end
    end
  end

  // AXI4-Lite: write ctrl selects which aux register is shown; others read only
  reg aw_got;
  reg w_got;
  reg [3:0] aw_hold;
  reg [31:0] w_hold;
  reg w_lane0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DAG_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_hold <= 4'h0;
      w_hold <= 32'h00000000;
      w_lane0 <= 1'b0;
      view_sel <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        if (aw_hold == `DAG_ADDR_CTRL) begin
          s_axi_bresp <= `DAG_RESP_OKAY;
          if (w_lane0) begin
            view_sel <= w_hold[2:0];
          end
        end else if (aw_hold == `DAG_ADDR_PAGE || aw_hold == `DAG_ADDR_AUX ||
                     aw_hold == `DAG_ADDR_STAT) begin
          s_axi_bresp <= `DAG_RESP_OKAY;
        end else begin
          s_axi_bresp <= `DAG_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DAG_RESP_OKAY;
      mem_hold <= 1'b0;
    end else begin
      mem_hold <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DAG_RESP_OKAY;
        case (s_axi_araddr)
          `DAG_ADDR_CTRL: s_axi_rdata <= {29'h0, view_sel};
          `DAG_ADDR_PAGE: s_axi_rdata <= {23'h0, data_page_pointer};
          `DAG_ADDR_AUX: s_axi_rdata <= {16'h0, aux_reg[view_sel]};
          `DAG_ADDR_STAT: s_axi_rdata <= {29'h0, aux_reg_select};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DAG_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== bench/dag_decoder_model.sv
/* Decoder stand-in: operand and mode legality from the opcode.
   Opcode ca is immediate, fe a branch, cb allows no mode. */
`timescale 1ns/1ns
module dag_decoder_model (
  // Opcode
  input wire [7:0] opcode,
  // Legality
  output wire uses_mem_operand,
  output wire direct_allowed,
  output wire indirect_allowed
);
  assign uses_mem_operand = opcode != 8'hca;
  assign direct_allowed = opcode != 8'hfe && opcode != 8'hcb;
  assign indirect_allowed = opcode != 8'hcb;
endmodule

// ===== bench/dag_checker_sva.sv
/* Port assertions for the address generator.
   Bound to dag_top; one clock, synchronous reset. */
`timescale 1ns/1ns
module dag_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Instruction
  input wire exec_valid,
  input wire [15:0] instr_word,
  input wire uses_mem_operand,
  input wire direct_allowed,
  input wire indirect_allowed,
  input wire load_page_immediate,
  input wire [8:0] page_value,
  input wire load_aux_from_memory,
  input wire load_aux_short,
  input wire load_aux_long,
  input wire add_aux_short,
  input wire sub_aux_short,
  input wire load_pointer,
  // Address bus
  input wire [15:0] data_addr,
  input wire data_addr_valid,
  input wire addr_mode_error
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire mem = exec_valid && uses_mem_operand;
  wire aux_ld = load_aux_from_memory | load_aux_short | load_aux_long | add_aux_short |
    sub_aux_short | load_pointer;
  wire dir_ok = mem && !instr_word[7] && direct_allowed;
  // Loads outrank post-modify, so those cycles are left out
  wire ind_ok = mem && instr_word[7] && indirect_allowed && !aux_ld;
  property p_direct;
    dir_ok |=> data_addr_valid && data_addr[6:0] == $past(instr_word[6:0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct offset wrong");
  property p_page;
    exec_valid && load_page_immediate ##1 dir_ok |=> data_addr[15:7] == $past(page_value, 2);
  endproperty
  a_page: assert property (p_page) else $error("page field wrong");
  property p_err_dir;
    mem && !instr_word[7] && !direct_allowed |=> addr_mode_error && !data_addr_valid;
  endproperty
  a_err_dir: assert property (p_err_dir) else $error("direct not refused");
  property p_err_ind;
    mem && instr_word[7] && !indirect_allowed |=> addr_mode_error && !data_addr_valid;
  endproperty
  a_err_ind: assert property (p_err_ind) else $error("indirect not refused");
  property p_idle;
    !exec_valid |=> !data_addr_valid && !addr_mode_error;
  endproperty
  a_idle: assert property (p_idle) else $error("output without instruction");
  property p_step(bit [2:0] op, bit [15:0] d);
    (ind_ok && instr_word[6:3] == {op, 1'b0}) [*2] |=> data_addr == $past(data_addr) + d;
  endproperty
  property p_inc; p_step(3'h2, 16'h0001); endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_dec; p_step(3'h1, 16'hffff); endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_rsvd; p_step(3'h3, 16'h0000); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved op changed register");
  c_direct: cover property (dir_ok);
  c_error: cover property (addr_mode_error);
  c_bitrev: cover property (ind_ok && instr_word[6:4] == 3'h7);
endmodule
bind dag_top dag_checker chk (.*);

// ===== bench/tb_top.sv
/* Self-checking bench for dag_top.
   Drives instructions and AXI4-Lite; a decoder model sets legality. */
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, exec_valid, load_page_from_memory, load_page_immediate;
  logic load_status_zero, load_aux_from_memory, load_aux_short, load_aux_long, add_aux_short;
  logic sub_aux_short, load_pointer, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [15:0] instr_word, aux_value;
  logic [8:0] page_value, page;
  logic [2:0] pointer_value, ptr;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, seed;
  wire [15:0] data_addr;
  wire data_addr_valid, addr_mode_error, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, uses_mem_operand, direct_allowed, indirect_allowed;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors = 0;
  int tests_run = 0;
  logic [16:0] q[$];
  logic [16:0] e;
  logic [15:0] ar[8];
  dag_top DUT (.*);
  dag_decoder_model dec (.opcode(instr_word[15:8]), .uses_mem_operand(uses_mem_operand),
    .direct_allowed(direct_allowed), .indirect_allowed(indirect_allowed));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  function [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    xs = x ^ (x << 5);
  endfunction
  function [15:0] rv(input [15:0] x);
    rv = {<<{x}};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Drives one instruction and advances the bench's own register model
  task op(input [15:0] iw, input [8:0] c, input [15:0] v);
    logic [15:0] a;
    @(posedge aclk);
    exec_valid <= 1;
    instr_word <= iw;
    aux_value <= v;
    page_value <= v[8:0];
    pointer_value <= v[2:0];
    {load_page_from_memory, load_page_immediate, load_status_zero, load_aux_from_memory,
      load_aux_short, load_aux_long, add_aux_short, sub_aux_short, load_pointer} <= c;
    a = ar[ptr];
    if (iw[15:8] == 8'hca) begin
      if (c[8:6] != 0) page = v[8:0];
      if (c[5:3] != 0) ar[ptr] = v;
      else if (c[2]) ar[ptr] = a + v;
      else if (c[1]) ar[ptr] = a - v;
      if (c[0]) ptr = v[2:0];
    end else if (iw[15:8] == 8'hcb || iw[15:7] == 9'h1fc) q.push_back(17'h10000);
    else if (!iw[7]) q.push_back({1'b0, page, iw[6:0]});
    else begin
      q.push_back({1'b0, a});
      case (iw[6:4])
        3'h1: ar[ptr] = a - 16'h1;
        3'h2: ar[ptr] = a + 16'h1;
        3'h4: ar[ptr] = rv(rv(a) - rv(ar[0]));
        3'h5: ar[ptr] = a - ar[0];
        3'h6: ar[ptr] = a + ar[0];
        3'h7: ar[ptr] = rv(rv(a) + rv(ar[0]));
        default: ;
      endcase
      if (iw[3]) ptr = iw[2:0];
    end
  endtask
  task axw(input [3:0] a, input [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(s_axi_bresp, 2'h0);
  endtask
  task axr(input [3:0] a, input [31:0] x, input [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rresp, r);
    if (r == 0) chk(s_axi_rdata, x);
  endtask
  always @(posedge aclk)
    if (aresetn && (data_addr_valid || addr_mode_error)) begin
      e = q.size() ? q.pop_front() : 17'h1ffff;
      chk({addr_mode_error, e[16] ? 16'h0 : data_addr}, e);
    end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    test_done;
  end
  initial begin
    {exec_valid, load_page_from_memory, load_page_immediate, load_status_zero, load_aux_from_memory,
      load_aux_short, load_aux_long, add_aux_short, sub_aux_short, load_pointer} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 0;
    {instr_word, aux_value, page_value, pointer_value, s_axi_awaddr, s_axi_araddr} = 0;
    {s_axi_wdata, ptr} = 0;
    s_axi_wstrb = 4'hf;
    seed = 32'hccd2;
    foreach (ar[i]) ar[i] = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      op(16'hca00, 9'h100 >> k, seed[15:0]);
      op({8'h05, 1'b0, seed[22:16]}, 0, 0);
    end
    op(16'hfe05, 0, 0);
    op(16'hcb85, 0, 0);
    op(16'hca00, 9'h001, 16'h1);
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      op(16'hca00, 9'h020 >> k, seed[15:0]);
      op(16'h0880, 0, 0);
    end
    op(16'hca00, 9'h001, 16'h0);
    op(16'hca00, 9'h008, seed[31:16]);
    op(16'hca00, 9'h001, 16'h1);
    for (int o = 0; o < 8; o++) begin
      seed = xs(seed);
      op(16'hca00, 9'h008, seed[15:0]);
      repeat (2) op({8'h08, 1'b1, o[2:0], !o[0], 3'h1}, 0, 0);
    end
    op(16'hca00, 9'h001, 16'h0);
    op(16'hca00, 9'h008, 16'h0008);
    op(16'hca00, 9'h001, 16'h1);
    op(16'hca00, 9'h008, 16'h0200);
    repeat (4) op(16'h08f0, 0, 0);
    op(16'hca00, 9'h008, 16'hffff);
    repeat (2) op(16'h08a0, 0, 0);
    op(16'h088a, 0, 0);
    op(16'h0880, 0, 0);
    @(posedge aclk);
    exec_valid <= 0;
    axw(4'h0, 32'h2);
    axr(4'h8, ar[2], 2'h0);
    axr(4'hc, ptr, 2'h0);
    axw(4'h4, 32'h0);
    axr(4'h4, page, 2'h0);
    axr(4'h2, 0, 2'h2);
    repeat (4) @(posedge aclk);
    test_done;
  end
endmodule
